/* hdl/ttp_pkg.sv */
`default_nettype none
package ttp_pkg;
    // Bus geometry
    localparam int unsigned ADDR_W = 12;
    localparam int unsigned DATA_W = 32;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // Register indices; byte address is four times the index
    localparam logic [7:0] IDX_MANUAL = 8'h10;
    localparam logic [7:0] IDX_HYST = 8'h11;
    localparam logic [7:0] IDX_CH_CFG0 = 8'h5f;
    localparam logic [7:0] IDX_CH_CFG1 = 8'h60;
    localparam logic [7:0] IDX_CH_CFG2 = 8'h61;
    localparam logic [7:0] IDX_ACOUSTIC = 8'h62;
    localparam logic [7:0] IDX_CRIT0 = 8'h6a;
    localparam logic [7:0] IDX_CRIT1 = 8'h6b;
    localparam logic [7:0] IDX_CRIT2 = 8'h6c;
    localparam logic [7:0] IDX_MASK2 = 8'h75;
    localparam logic [7:0] IDX_CFG3 = 8'h78;
    localparam logic [7:0] IDX_TIMER = 8'h79;
    localparam logic [7:0] IDX_TLIMIT = 8'h7a;
    localparam logic [7:0] IDX_CFG5 = 8'h7c;
    localparam logic [7:0] IDX_CFG4 = 8'h7d;
    localparam logic [7:0] IDX_STATUS = 8'h80;
    localparam logic [7:0] IDX_AUX = 8'h81;
    localparam logic [7:0] REG_RESET = 8'h00;
    // Field positions
    localparam int unsigned B_CFG3_ENABLE = 1;
    localparam int unsigned B_CFG3_FULL_SPEED_ON_THROTTLE = 2;
    localparam int unsigned B_CFG4_DISABLE = 2;
    localparam int unsigned B_CFG4_MAXSEL = 3;
    localparam int unsigned B_MANUAL_OVR = 3;
    localparam int unsigned B_HYST_DIS = 0;
    localparam int unsigned B_CH_OUT_EN = 3;
    localparam int unsigned B_CFG5_CH0 = 5;
    localparam int unsigned B_MASK_TIMER = 5;
    localparam int unsigned B_SYNC_SHARE = 4;
    localparam int unsigned B_STATUS_FLAG = 5;
    localparam int unsigned B_AUX_OFFSET = 0;
    localparam int unsigned N_CHAN = 3;
    localparam int unsigned N_TACH = 4;
    // Shared pin function select codes
    typedef enum logic [1:0] {
        PIN_FAN_SPEED_INPUT_4 = 2'h0,
        PIN_THROTTLE = 2'h1,
        PIN_ALERT = 2'h2,
        PIN_GPIO = 2'h3
    } ttp_pin_func_t;
    // Tach sync source codes
    localparam logic [1:0] SYNC_FAN1 = 2'h0;
    localparam logic [1:0] SYNC_FAN2 = 2'h1;
    localparam logic [1:0] SYNC_FAN3 = 2'h2;
    localparam logic [1:0] SYNC_NONE = 2'h3;
    // Duty and limit figures
    localparam logic [7:0] DUTY_FULL = 8'hff;
    localparam logic [7:0] DUTY_ZERO = 8'h00;
    localparam logic [7:0] TIMER_MAX = 8'hff;
    localparam logic [7:0] TIMER_FIRST = 8'h01;
    localparam logic [7:0] LIM_OFFSET_MAX = 8'h80;
    localparam logic signed [8:0] LIM_TWOS_MAX = 9'sh080;
    localparam logic [7:0] TWOS_FLIP = 8'h80;
    // Throttle timer resolution
    localparam int unsigned CLK_HZ = 10000000;
    localparam real TIMER_LSB_MS = 22.76;
    localparam int unsigned TIMER_TICK_CYCLES = int'(TIMER_LSB_MS * real'(CLK_HZ) / 1000.0);
    // Carriers
    typedef struct packed {
        logic [1:0] chan;
        logic [9:0] temp;
    } ttp_sample_t;
    typedef logic [2:0][7:0] ttp_duty3_t;
    typedef logic [3:0][1:0] ttp_tach_sync_t;
endpackage
`default_nettype wire

/* hdl/ttp_throttle_ctrl.sv */
// What this block does
// - Timer monitoring only with enable bit; off at reset
// - Pin function needs select code and enable bit
// - Select codes: fan_speed_input_4, throttle, alert, GPIO
// - Full_speed_on_throttle drives running fans full while pin asserted
// - Full_speed_on_throttle bit clear leaves fan outputs unchanged
// - Stopped fans are never boosted
// - Mask bit blocks alert, flag still set
// - Zero limit alerts on first pin assertion
// - Drive pin low when temperature exceeds limit
// - Stay low until temperature at or below limit
// - Asserted output held at least one monitoring cycle while channel and pin function stay enabled
// - Three critical limit registers, consecutive addresses
// - Per-channel config bit 3 enables output
// - Limits at or below 0x80 (offset mode) or any limit (two's complement mode) disable channel output
// - Three-bit field enables channels individually
// - Hysteresis-disable bit turns hysteresis off
// - Disable bit blocks pin unless hysteresis off
// - Manual mode boosts only with override bit
// - Select full duty or programmed maximum on full_speed_on_throttle
// - Disable bit stops throttle changing fan outputs
// - Default tach sync: own fan, fan_speed_input_4 to fan3
// - Sharing bit syncs fan_speed_input_2..4 to fan3
// - High-frequency four-wire mode needs no sync
`default_nettype none
module ttp_throttle_ctrl #(
    parameter int unsigned TIMER_TICK_CYCLES = ttp_pkg::TIMER_TICK_CYCLES
) (
    input wire logic i_mclk,
    input wire logic i_nrst,
    input wire logic i_awvalid,
    input wire logic [ttp_pkg::ADDR_W-1:0] i_awaddr,
    output logic o_awready,
    input wire logic i_wvalid,
    input wire logic [ttp_pkg::DATA_W-1:0] i_wdata,
    input wire logic [3:0] i_wstrb,
    output logic o_wready,
    output logic o_bvalid,
    output logic [1:0] o_bresp,
    input wire logic i_bready,
    input wire logic i_arvalid,
    input wire logic [ttp_pkg::ADDR_W-1:0] i_araddr,
    output logic o_arready,
    output logic o_rvalid,
    output logic [ttp_pkg::DATA_W-1:0] o_rdata,
    output logic [1:0] o_rresp,
    input wire logic i_rready,
    input wire logic i_thermal_throttle_pin_pin_n,
    output logic o_thermal_throttle_pin_pin_out,
    output logic o_thermal_throttle_pin_pin_oe,
    input wire logic i_sample_valid,
    input wire ttp_pkg::ttp_sample_t i_sample,
    input wire logic i_manual_mode,
    input wire logic [2:0] i_above_tmin,
    input wire ttp_pkg::ttp_duty3_t i_fan_duty,
    input wire ttp_pkg::ttp_duty3_t i_fan_max_duty,
    input wire logic i_hf_4wire,
    output ttp_pkg::ttp_duty3_t o_fan_duty,
    output ttp_pkg::ttp_tach_sync_t o_tach_sync,
    output logic o_alert
);
    import ttp_pkg::*;
    ////////////////////////////////////////////////////////////////////////
    logic [7:0] manual_reg, hyst_reg, acoustic_reg, mask2_reg, cfg3_reg, cfg5_reg, cfg4_reg, aux_reg;
    logic [7:0] tlimit_reg, timer_reg, aw_idx_reg, wbyte_reg, ar_idx;
    logic [2:0][7:0] ch_cfg_reg, crit_reg;
    logic flag_reg, aw_hold_reg, w_hold_reg, aw_ok_reg, wlane_reg;
    logic do_write, ar_fire, rd_timer, flag_clr, ar_ok;
    function automatic logic idx_mapped(input logic [7:0] idx);
        unique case (idx)
            IDX_MANUAL, IDX_HYST, IDX_CH_CFG0, IDX_CH_CFG1, IDX_CH_CFG2, IDX_ACOUSTIC,
            IDX_CRIT0, IDX_CRIT1, IDX_CRIT2, IDX_MASK2, IDX_CFG3, IDX_TIMER, IDX_TLIMIT,
            IDX_CFG5, IDX_CFG4, IDX_STATUS, IDX_AUX: idx_mapped = 1'b1;
            default: idx_mapped = 1'b0;
        endcase
    endfunction
    assign ar_idx = i_araddr[9:2];
    assign ar_ok = (i_araddr[ADDR_W-1:10] == '0) && idx_mapped(ar_idx);
    assign ar_fire = i_arvalid && o_arready;
    assign rd_timer = ar_fire && ar_ok && (ar_idx == IDX_TIMER);
    assign do_write = aw_hold_reg && w_hold_reg && !o_bvalid;
    ////////////////////////////////////////////////////////////////////////
    // Write channel: address and data taken in either order
    always_ff @(posedge i_mclk) begin
        if (!i_nrst) begin
            aw_hold_reg <= 1'b0;
            w_hold_reg <= 1'b0;
            aw_idx_reg <= 8'h00;
            aw_ok_reg <= 1'b0;
            wbyte_reg <= 8'h00;
            wlane_reg <= 1'b0;
            o_awready <= 1'b0;
            o_wready <= 1'b0;
            o_bvalid <= 1'b0;
            o_bresp <= RESP_OKAY;
        end else begin
            if (i_awvalid && o_awready) begin
                aw_hold_reg <= 1'b1;
                aw_idx_reg <= i_awaddr[9:2];
                aw_ok_reg <= (i_awaddr[ADDR_W-1:10] == '0) && idx_mapped(i_awaddr[9:2]);
                o_awready <= 1'b0;
            end else if (!aw_hold_reg && !o_bvalid) begin
                o_awready <= 1'b1;
            end
            if (i_wvalid && o_wready) begin
                w_hold_reg <= 1'b1;
                wbyte_reg <= i_wdata[7:0];
                wlane_reg <= i_wstrb[0];
                o_wready <= 1'b0;
            end else if (!w_hold_reg && !o_bvalid) begin
                o_wready <= 1'b1;
            end
            if (do_write) begin
                aw_hold_reg <= 1'b0;
                w_hold_reg <= 1'b0;
                o_bvalid <= 1'b1;
                o_bresp <= aw_ok_reg ? RESP_OKAY : RESP_SLVERR;
            end else if (o_bvalid && i_bready) begin
                o_bvalid <= 1'b0;
            end
        end
    end
    // Register store; only byte lane 0 carries data
    always_ff @(posedge i_mclk) begin
        if (!i_nrst) begin
            manual_reg <= REG_RESET;
            hyst_reg <= REG_RESET;
            acoustic_reg <= REG_RESET;
            mask2_reg <= REG_RESET;
            cfg3_reg <= REG_RESET;
            cfg5_reg <= REG_RESET;
            cfg4_reg <= REG_RESET;
            aux_reg <= REG_RESET;
            tlimit_reg <= REG_RESET;
            ch_cfg_reg <= '0;
            crit_reg <= '0;
        end else if (do_write && aw_ok_reg && wlane_reg) begin
            unique case (aw_idx_reg)
                IDX_MANUAL: manual_reg <= wbyte_reg;
                IDX_HYST: hyst_reg <= wbyte_reg;
                IDX_CH_CFG0: ch_cfg_reg[0] <= wbyte_reg;
                IDX_CH_CFG1: ch_cfg_reg[1] <= wbyte_reg;
                IDX_CH_CFG2: ch_cfg_reg[2] <= wbyte_reg;
                IDX_ACOUSTIC: acoustic_reg <= wbyte_reg;
                IDX_CRIT0: crit_reg[0] <= wbyte_reg;
                IDX_CRIT1: crit_reg[1] <= wbyte_reg;
                IDX_CRIT2: crit_reg[2] <= wbyte_reg;
                IDX_MASK2: mask2_reg <= wbyte_reg;
                IDX_CFG3: cfg3_reg <= wbyte_reg;
                IDX_TLIMIT: tlimit_reg <= wbyte_reg;
                IDX_CFG5: cfg5_reg <= wbyte_reg;
                IDX_CFG4: cfg4_reg <= wbyte_reg;
                IDX_AUX: aux_reg <= wbyte_reg;
                default: ;
            endcase
        end
    end
    assign flag_clr = do_write && aw_ok_reg && wlane_reg && (aw_idx_reg == IDX_STATUS) && wbyte_reg[B_STATUS_FLAG];
    ////////////////////////////////////////////////////////////////////////
    // Read channel, one access at a time
    function automatic logic [7:0] read_value(input logic [7:0] idx);
        unique case (idx)
            IDX_MANUAL: read_value = manual_reg;
            IDX_HYST: read_value = hyst_reg;
            IDX_CH_CFG0: read_value = ch_cfg_reg[0];
            IDX_CH_CFG1: read_value = ch_cfg_reg[1];
            IDX_CH_CFG2: read_value = ch_cfg_reg[2];
            IDX_ACOUSTIC: read_value = acoustic_reg;
            IDX_CRIT0: read_value = crit_reg[0];
            IDX_CRIT1: read_value = crit_reg[1];
            IDX_CRIT2: read_value = crit_reg[2];
            IDX_MASK2: read_value = mask2_reg;
            IDX_CFG3: read_value = cfg3_reg;
            IDX_TIMER: read_value = timer_reg;
            IDX_TLIMIT: read_value = tlimit_reg;
            IDX_CFG5: read_value = cfg5_reg;
            IDX_CFG4: read_value = cfg4_reg;
            IDX_STATUS: read_value = 8'(flag_reg) << B_STATUS_FLAG;
            IDX_AUX: read_value = aux_reg;
            default: read_value = 8'h00;
        endcase
    endfunction
    always_ff @(posedge i_mclk) begin
        if (!i_nrst) begin
            o_arready <= 1'b0;
            o_rvalid <= 1'b0;
            o_rdata <= '0;
            o_rresp <= RESP_OKAY;
        end else if (ar_fire) begin
            o_arready <= 1'b0;
            o_rvalid <= 1'b1;
            o_rdata <= {24'h000000, ar_ok ? read_value(ar_idx) : 8'h00};
            o_rresp <= ar_ok ? RESP_OKAY : RESP_SLVERR;
        end else if (o_rvalid && i_rready) begin
            o_rvalid <= 1'b0;
        end else if (!o_rvalid) begin
            o_arready <= 1'b1;
        end
    end
    ////////////////////////////////////////////////////////////////////////
    // Pin input, function select and throttle timer
    logic pin_s1_reg, pin_s2_reg, in_prev_reg, fn_active, pin_asserted;
    logic [31:0] tick_reg;
    logic [1:0] oe_dly_reg;
    always_ff @(posedge i_mclk) begin
        if (!i_nrst) begin
            pin_s1_reg <= 1'b1;
            pin_s2_reg <= 1'b1;
            oe_dly_reg <= 2'b00;
        end else begin
            pin_s1_reg <= i_thermal_throttle_pin_pin_n;
            pin_s2_reg <= pin_s1_reg;
            oe_dly_reg <= {oe_dly_reg[0], o_thermal_throttle_pin_pin_oe};
        end
    end
    assign fn_active = (ttp_pin_func_t'(cfg4_reg[1:0]) == PIN_THROTTLE) && cfg3_reg[B_CFG3_ENABLE];
    // Our own low drive is not an external assertion; it lingers in the synchroniser two cycles
    assign pin_asserted = fn_active && !pin_s2_reg && !o_thermal_throttle_pin_pin_oe && !(|oe_dly_reg);
    always_ff @(posedge i_mclk) begin
        if (!i_nrst) begin
            in_prev_reg <= 1'b0;
            tick_reg <= '0;
            timer_reg <= 8'h00;
        end else begin
            in_prev_reg <= pin_asserted;
            if (rd_timer) begin
                // Clear on read, but a live assertion restarts at one
                timer_reg <= pin_asserted ? TIMER_FIRST : 8'h00;
                tick_reg <= '0;
            end else if (pin_asserted) begin
                if (!in_prev_reg && timer_reg == 8'h00) begin
                    timer_reg <= TIMER_FIRST;
                end else if (tick_reg == TIMER_TICK_CYCLES - 1) begin
                    tick_reg <= '0;
                    if (timer_reg != TIMER_MAX) begin
                        timer_reg <= timer_reg + 8'h01;
                    end
                end else begin
                    tick_reg <= tick_reg + 32'd1;
                end
            end
        end
    end
    // Set wins over a software clear in the same cycle
    always_ff @(posedge i_mclk) begin
        if (!i_nrst) begin
            flag_reg <= 1'b0;
            o_alert <= 1'b0;
        end else begin
            if (fn_active && timer_reg > tlimit_reg) begin
                flag_reg <= 1'b1;
            end else if (flag_clr) begin
                flag_reg <= 1'b0;
            end
            o_alert <= flag_reg && !mask2_reg[B_MASK_TIMER];
        end
    end
    ////////////////////////////////////////////////////////////////////////
    // Over-temperature output, one latch per channel
    function automatic logic [7:0] to_order(input logic [7:0] code, input logic offset_mode);
        to_order = offset_mode ? code : (code ^ TWOS_FLIP);
    endfunction
    function automatic logic limit_live(input logic [7:0] lim, input logic offset_mode);
        limit_live = offset_mode ? (lim > LIM_OFFSET_MAX) : ($signed({lim[7], lim}) > LIM_TWOS_MAX);
    endfunction
    logic [2:0] hot_reg, ch_en, fan_running;
    logic offset_mode, drive_pin, full_speed_on_throttle_gate;
    assign offset_mode = aux_reg[B_AUX_OFFSET];
    generate
        for (genvar c = 0; c < N_CHAN; c++) begin : g_chan
            logic over;
            assign ch_en[c] = ch_cfg_reg[c][B_CH_OUT_EN] && cfg5_reg[B_CFG5_CH0 + c]
                && limit_live(crit_reg[c], offset_mode);
            // Strict compare with two fraction bits: a quarter degree above trips
            assign over = {to_order(i_sample.temp[9:2], offset_mode), i_sample.temp[1:0]}
                > {to_order(crit_reg[c], offset_mode), 2'b00};
            // Re-evaluated on this channel's strobe, cleared at once when ch_en drops; while enabled a trip lasts a full cycle
            always_ff @(posedge i_mclk) begin
                if (!i_nrst) begin
                    hot_reg[c] <= 1'b0;
                end else if (!ch_en[c]) begin
                    hot_reg[c] <= 1'b0;
                end else if (i_sample_valid && i_sample.chan == 2'(c)) begin
                    hot_reg[c] <= over;
                end
            end
        end
    endgenerate
    assign drive_pin = fn_active && (|hot_reg)
        && (!cfg4_reg[B_CFG4_DISABLE] || hyst_reg[B_HYST_DIS]);
    always_ff @(posedge i_mclk) begin
        if (!i_nrst) begin
            o_thermal_throttle_pin_pin_oe <= 1'b0;
            o_thermal_throttle_pin_pin_out <= 1'b0;
        end else begin
            o_thermal_throttle_pin_pin_oe <= drive_pin;
            o_thermal_throttle_pin_pin_out <= 1'b0;
        end
    end
    ////////////////////////////////////////////////////////////////////////
    // Fan full_speed_on_throttle while the pin is held low from outside
    assign full_speed_on_throttle_gate = pin_asserted && cfg3_reg[B_CFG3_FULL_SPEED_ON_THROTTLE] && !cfg4_reg[B_CFG4_DISABLE]
        && (!i_manual_mode || manual_reg[B_MANUAL_OVR]);
    generate
        for (genvar f = 0; f < N_CHAN; f++) begin : g_fan
            assign fan_running[f] = i_manual_mode ? (i_fan_duty[f] != DUTY_ZERO) : i_above_tmin[f];
            always_ff @(posedge i_mclk) begin
                if (!i_nrst) begin
                    o_fan_duty[f] <= DUTY_ZERO;
                end else if (full_speed_on_throttle_gate && fan_running[f]) begin
                    o_fan_duty[f] <= cfg4_reg[B_CFG4_MAXSEL] ? i_fan_max_duty[f] : DUTY_FULL;
                end else begin
                    o_fan_duty[f] <= i_fan_duty[f];
                end
            end
        end
    endgenerate
    ////////////////////////////////////////////////////////////////////////
    // Tach sampling synchronisation
    always_ff @(posedge i_mclk) begin
        if (!i_nrst) begin
            o_tach_sync <= {SYNC_FAN3, SYNC_FAN3, SYNC_FAN2, SYNC_FAN1};
        end else if (i_hf_4wire) begin
            o_tach_sync <= {SYNC_NONE, SYNC_NONE, SYNC_NONE, SYNC_NONE};
        end else if (acoustic_reg[B_SYNC_SHARE]) begin
            o_tach_sync <= {SYNC_FAN3, SYNC_FAN3, SYNC_FAN3, SYNC_FAN1};
        end else begin
            o_tach_sync <= {SYNC_FAN3, SYNC_FAN3, SYNC_FAN2, SYNC_FAN1};
        end
    end
    ////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (!i_nrst);
    AST_PIN_NEEDS_ENABLE: assert property (!fn_active |=> !o_thermal_throttle_pin_pin_oe)
        else $error("Throttle pin driven while function inactive");
    AST_NO_INPUT_WITHOUT_FN: assert property (!fn_active |-> !pin_asserted ##1 !flag_reg || $past(flag_reg))
        else $error("Flag raised while pin function inactive");
    AST_FULL_SPEED_ON_THROTTLE_FULL: assert property (full_speed_on_throttle_gate && fan_running[0] && !cfg4_reg[B_CFG4_MAXSEL]
        |=> o_fan_duty[0] == DUTY_FULL)
        else $error("Full_speed_on_throttle did not reach full duty");
    AST_FULL_SPEED_ON_THROTTLE_OFF: assert property (!cfg3_reg[B_CFG3_FULL_SPEED_ON_THROTTLE] |=> o_fan_duty == $past(i_fan_duty))
        else $error("Fan output changed without full_speed_on_throttle");
    AST_STOPPED_FAN: assert property (i_manual_mode && i_fan_duty[1] == DUTY_ZERO |=> o_fan_duty[1] == DUTY_ZERO)
        else $error("Stopped fan was boosted");
    AST_MASKED_ALERT: assert property (mask2_reg[B_MASK_TIMER] |=> !o_alert)
        else $error("Alert not masked");
    AST_ZERO_LIMIT: assert property (tlimit_reg == 8'h00 && pin_asserted && !in_prev_reg && !rd_timer
        |-> ##[1:2] flag_reg)
        else $error("Zero limit did not flag first assertion");
    AST_TRIP: assert property (ch_en[0] && i_sample_valid && i_sample.chan == 2'h0 && g_chan[0].over && fn_active
        && !cfg4_reg[B_CFG4_DISABLE] && $stable(cfg4_reg) && $stable(cfg3_reg) |=> ##1 o_thermal_throttle_pin_pin_oe)
        else $error("Over-temperature did not drive pin");
    AST_HOLD: assert property (hot_reg[0] && ch_en[0] && !(i_sample_valid && i_sample.chan == 2'h0)
        |=> hot_reg[0])
        else $error("Trip released between samples");
    AST_DISABLE_FANS: assert property (cfg4_reg[B_CFG4_DISABLE] |=> o_fan_duty == $past(i_fan_duty))
        else $error("Throttle changed fans while disabled");
    AST_TACH_SHARE: assert property (acoustic_reg[B_SYNC_SHARE] && !i_hf_4wire |=> o_tach_sync[1] == SYNC_FAN3)
        else $error("Tach sharing not applied");
    COV_FULL_SPEED_ON_THROTTLE: cover property (full_speed_on_throttle_gate && fan_running[0] ##1 o_fan_duty[0] == DUTY_FULL);
    COV_TRIP_RELEASE: cover property (o_thermal_throttle_pin_pin_oe ##[1:50] !o_thermal_throttle_pin_pin_oe);
    COV_ALERT: cover property (flag_reg && o_alert);
    COV_TIMER_READ: cover property (rd_timer && pin_asserted);
endmodule
`default_nettype wire

/* verification/ttp_cpu_hot_model.sv */
`default_nettype none
module ttp_cpu_hot_model (
    input wire logic i_cpu_hot,
    input wire logic i_dev_out,
    input wire logic i_dev_oe,
    output logic o_pin_n
);
    timeunit 1ns;
    timeprecision 1ns;
    // Pulled-up open-drain line: low while either party pulls it
    assign o_pin_n = !(i_cpu_hot || (i_dev_oe && !i_dev_out));
endmodule
`default_nettype wire

/* verification/thermal_throttle_pin_control_tb_top.sv */
`default_nettype none
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin errors++; \
    $display("mismatch t=%0t got=%h exp=%h", $time, a, b); end end
module thermal_throttle_pin_control_tb_top import ttp_pkg::*; ;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 0, nrst = 0, awv = 0, wv = 0, bry = 0, arv = 0, rry = 0, sv = 0, man = 0, hf = 0, hot = 0;
    logic [ADDR_W-1:0] awa = '0, ara = '0;
    logic [DATA_W-1:0] wd = '0, rd;
    logic [2:0] tmin = 3'h5;
    ttp_sample_t smp = '0;
    ttp_duty3_t fd = {8'h30, 8'h20, 8'h10}, fm = {8'h70, 8'h60, 8'h50}, od;
    ttp_tach_sync_t ts;
    logic awr, wrd, bv, arr, rv, pout, poe, pin_n, alert;
    logic [1:0] br, rr;
    int errors = 0, total_checks = 0, cyc = 0;
    ttp_throttle_ctrl #(.TIMER_TICK_CYCLES(8)) uut (.i_mclk(clk), .i_nrst(nrst), .i_awvalid(awv),
        .i_awaddr(awa), .o_awready(awr), .i_wvalid(wv), .i_wdata(wd), .i_wstrb(4'hf), .o_wready(wrd),
        .o_bvalid(bv), .o_bresp(br), .i_bready(bry), .i_arvalid(arv), .i_araddr(ara), .o_arready(arr),
        .o_rvalid(rv), .o_rdata(rd), .o_rresp(rr), .i_rready(rry), .i_thermal_throttle_pin_pin_n(pin_n),
        .o_thermal_throttle_pin_pin_out(pout), .o_thermal_throttle_pin_pin_oe(poe), .i_sample_valid(sv), .i_sample(smp),
        .i_manual_mode(man), .i_above_tmin(tmin), .i_fan_duty(fd), .i_fan_max_duty(fm),
        .i_hf_4wire(hf), .o_fan_duty(od), .o_tach_sync(ts), .o_alert(alert));
    ttp_cpu_hot_model partner (.i_cpu_hot(hot), .i_dev_out(pout), .i_dev_oe(poe), .o_pin_n(pin_n));
    initial forever #50 clk = ~clk;
    ////////////////////////////////////////////////////////////////////////////////
    task automatic end_sim();
        $display("checks=%0d errors=%0d", total_checks, errors);
        if (errors == 0 && total_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    // Ceiling well above the couple of hundred cycles the scenarios need
    always @(posedge clk) begin
        cyc++;
        if (cyc > 20000) begin
            errors++;
            end_sim();
        end
    end
    task automatic wr(input logic [7:0] i, input logic [7:0] d, input logic [1:0] er = RESP_OKAY);
        logic a, w;
        a = 0;
        w = 0;
        awv <= 1;
        wv <= 1;
        awa <= {2'h0, i, 2'h0};
        wd <= {24'h0, d};
        while (!(a && w)) begin
            @(posedge clk);
            if (awv && awr === 1'b1) begin
                a = 1;
                awv <= 0;
            end
            if (wv && wrd === 1'b1) begin
                w = 1;
                wv <= 0;
            end
        end
        bry <= 1;
        do @(posedge clk); while (bv !== 1'b1);
        bry <= 0;
        `CHK(br, er)
    endtask
    task automatic rdc(input logic [7:0] i, input logic [7:0] e, input logic [1:0] er = RESP_OKAY);
        arv <= 1;
        ara <= {2'h0, i, 2'h0};
        do @(posedge clk); while (arr !== 1'b1);
        arv <= 0;
        rry <= 1;
        do @(posedge clk); while (rv !== 1'b1);
        rry <= 0;
        `CHK(rd, {24'h0, e})
        `CHK(rr, er)
    endtask
    task automatic smp_t(input logic [9:0] t);
        sv <= 1;
        smp <= '{chan: 2'h0, temp: t};
        @(posedge clk);
        sv <= 0;
        repeat (3) @(posedge clk);
    endtask
    task automatic bchk(input ttp_duty3_t e);
        repeat (5) @(posedge clk);
        `CHK(od, e)
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_reset();
        `CHK(ts, {2'h2, 2'h2, 2'h1, 2'h0})
        rdc(IDX_CFG3, 8'h00);
        rdc(8'h00, 8'h00, RESP_SLVERR);
        wr(8'h00, 8'h55, RESP_SLVERR);
        wr(IDX_ACOUSTIC, 8'h10);
        repeat (2) @(posedge clk);
        `CHK(ts, {2'h2, 2'h2, 2'h2, 2'h0})
        hf <= 1;
        repeat (2) @(posedge clk);
        `CHK(ts, 8'hff)
        hf <= 0;
    endtask
    task automatic t_timer();
        wr(IDX_CFG4, 8'h01);
        hot <= 1;
        repeat (8) @(posedge clk);
        rdc(IDX_TIMER, 8'h00);
        `CHK(alert, 1'b0)
        hot <= 0;
        wr(IDX_MASK2, 8'h20);
        wr(IDX_CFG3, 8'h02);
        hot <= 1;
        repeat (8) @(posedge clk);
        `CHK(alert, 1'b0)
        rdc(IDX_STATUS, 8'h20);
        wr(IDX_MASK2, 8'h00);
        repeat (3) @(posedge clk);
        `CHK(alert, 1'b1)
        hot <= 0;
        // Raise the limit first, or the still-exceeded timer sets the flag again at once
        wr(IDX_TLIMIT, 8'hff);
        wr(IDX_STATUS, 8'h20);
        rdc(IDX_STATUS, 8'h00);
        `CHK(alert, 1'b0)
    endtask
    task automatic t_full_speed_on_throttle();
        hot <= 1;
        wr(IDX_CFG3, 8'h06);
        bchk({8'hff, 8'h20, 8'hff});
        wr(IDX_CFG4, 8'h09);
        bchk({8'h70, 8'h20, 8'h50});
        wr(IDX_CFG4, 8'h05);
        bchk(fd);
        man <= 1;
        wr(IDX_CFG4, 8'h01);
        bchk(fd);
        wr(IDX_MANUAL, 8'h08);
        bchk(24'hffffff);
        wr(IDX_CFG3, 8'h02);
        bchk(fd);
        hot <= 0;
        man <= 0;
    endtask
    task automatic t_out();
        wr(IDX_CH_CFG0, 8'h08);
        wr(IDX_CFG5, 8'h20);
        wr(IDX_CRIT0, 8'h90);
        smp_t(10'h241);
        `CHK(poe, 1'b0)
        wr(IDX_AUX, 8'h01);
        smp_t(10'h241);
        `CHK(poe, 1'b1)
        `CHK(pout, 1'b0)
        smp_t(10'h241);
        `CHK(poe, 1'b1)
        smp_t(10'h240);
        `CHK(poe, 1'b0)
        wr(IDX_CFG4, 8'h05);
        smp_t(10'h241);
        `CHK(poe, 1'b0)
        wr(IDX_HYST, 8'h01);
        smp_t(10'h241);
        `CHK(poe, 1'b1)
        wr(IDX_CFG4, 8'h02);
        repeat (2) @(posedge clk);
        `CHK(poe, 1'b0)
    endtask
    initial begin
        repeat (2) @(posedge clk);
        nrst <= 1;
        @(posedge clk);
        t_reset();
        t_timer();
        t_full_speed_on_throttle();
        t_out();
        end_sim();
    end
endmodule
`default_nettype wire
